/* core/cpu_regs_pkg.sv */
package cpu_regs_pkg;

    // ------------------------------------------------------------------
    // Data-space locations
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_FIRST_PTR = 8'h80;
    localparam logic [7:0] ADDR_SECOND_PTR = 8'h81;
    localparam logic [7:0] ADDR_SLOT_A = 8'h82;
    localparam logic [7:0] ADDR_SLOT_B = 8'h83;
    localparam logic [7:0] ADDR_ACCUM = 8'hff;

    // ------------------------------------------------------------------
    // Program counter and stack
    // ------------------------------------------------------------------
    localparam int PC_WIDTH = 12;
    localparam int STACK_DEPTH = 6;
    localparam logic [11:0] RESET_VECTOR = 12'hffe;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam int SHORT_DIRECT_CYCLES = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CTX_MAIN,
        CTX_IRQ,
        CTX_NMI
    } ctx_type;

    typedef enum logic [2:0] {
        PC_HOLD,
        PC_INCREMENT,
        PC_RELATIVE,
        PC_JUMP,
        PC_CALL,
        PC_VECTOR,
        PC_RETURN,
        PC_IRET
    } pc_op_type;

    typedef struct packed {
        logic carry;
        logic zero;
    } flags_type;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } data_wr_type;

    typedef struct packed {
        logic carry_we;
        logic carry;
        logic zero_we;
        logic zero;
    } flag_upd_type;

    typedef struct packed {
        pc_op_type op;
        logic [11:0] target;
        logic [7:0] offset;
        logic to_nmi;
    } pc_cmd_type;

endpackage

/* core/cpu_register_file_flag_banks.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01: 8-bit accumulator for all ALU work, also data-space location FFh.
// RULE_02: Two 8-bit index pointers at data-space 80h and 81h.
// RULE_03: Two 8-bit short-direct registers at data-space 82h and 83h.
// RULE_04: Short-direct access is a one-byte, four-cycle instruction.
// RULE_05: Short-direct mode also reaches both index pointers.
// RULE_06: Program counter is 12 bits, covering 4096 bytes.
// RULE_07: Ordinary instruction advances the program counter by one.
// RULE_08: Relative branch adds signed offset to program counter via the ALU; the code uses its own rel_sum adder.
// RULE_09: PC loads jump, call, vector, reset vector or stack pop.
// RULE_10: Three carry/zero pairs: main, interrupt and non-maskable contexts.
// RULE_11: Taking an interrupt switches at once to that context's flag pair.
// RULE_12: Interrupt return restores the previously active flag pair.
// RULE_13: Only the active context's flag pair is readable or writable.
// RULE_14: Context switches never clear flags; all pairs keep their values.
// RULE_15: Carry follows ALU carry or borrow, bit tests and rotate-left.
// RULE_16: Zero is set when the last arithmetic or logic result is zero.
// RULE_17: After reset the non-maskable context and its flags are active.
// RULE_18: Six-level 12-bit return stack; push drops deepest, pop loads PC.
module cpu_register_file_flag_banks #(
    parameter int STACK_LEVELS = 6
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input cpu_regs_pkg::data_wr_type data_wr,
    input wire logic [7:0] data_rd_addr,
    output logic [7:0] data_rd_data,
    output logic data_rd_hit,
    input wire logic [1:0] short_sel,
    output logic [7:0] short_rd_data,
    input wire logic accum_we,
    input wire logic [7:0] accum_alu_data,
    input cpu_regs_pkg::flag_upd_type flag_upd,
    output cpu_regs_pkg::flags_type active_flags,
    output cpu_regs_pkg::ctx_type active_ctx,
    input cpu_regs_pkg::pc_cmd_type pc_cmd,
    output logic [11:0] program_counter,
    output logic [7:0] accumulator_out,
    output logic [7:0] first_pointer_out,
    output logic [7:0] second_pointer_out,
    output logic [2:0] stack_level
);
    import cpu_regs_pkg::*;

    // The level counter is three bits wide, so deeper stacks are refused.
    if (STACK_LEVELS < 1 || STACK_LEVELS > 7) begin
        $error("STACK_LEVELS must be 1 to 7");
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // Reset takes hold at once but is let go through two flops, so every
    // register leaves reset on the same edge and none sees a runt release.
    // The cost is two idle cycles before the first command is taken.
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire logic rst_n = rst_sync_r;

    // Slot order follows the data-space order, so both index pointers sit
    // in front of the two dedicated short-direct registers.
    function automatic logic [7:0] sel_short(input logic [1:0] sel,
                                             input logic [7:0] p0,
                                             input logic [7:0] p1,
                                             input logic [7:0] s0,
                                             input logic [7:0] s1);
        logic [7:0] v;
        case (sel)
            2'd0: v = p0;
            2'd1: v = p1;
            2'd2: v = s0;
            default: v = s1;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Data-space registers
    // ------------------------------------------------------------------
    logic [7:0] accumulator_r, accumulator_nxt;
    logic [7:0] first_pointer_r, first_pointer_nxt;
    logic [7:0] second_pointer_r, second_pointer_nxt;
    logic [7:0] short_slot_a_r, short_slot_a_nxt;
    logic [7:0] short_slot_b_r, short_slot_b_nxt;

    // A data-space write wins over an ALU result landing in the same
    // cycle, since the sequencer never issues both for one instruction.
    always_comb begin
        accumulator_nxt = accumulator_r;
        first_pointer_nxt = first_pointer_r;
        second_pointer_nxt = second_pointer_r;
        short_slot_a_nxt = short_slot_a_r;
        short_slot_b_nxt = short_slot_b_r;
        if (accum_we) begin
            accumulator_nxt = accum_alu_data; // see RULE_01
        end
        if (data_wr.wr) begin
            case (data_wr.addr)
                ADDR_ACCUM: accumulator_nxt = data_wr.data; // see RULE_01
                ADDR_FIRST_PTR: first_pointer_nxt = data_wr.data; // see RULE_02
                ADDR_SECOND_PTR: second_pointer_nxt = data_wr.data; // see RULE_02
                ADDR_SLOT_A: short_slot_a_nxt = data_wr.data; // see RULE_03
                ADDR_SLOT_B: short_slot_b_nxt = data_wr.data; // see RULE_03
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator_r <= DATA_RESET;
            first_pointer_r <= DATA_RESET;
            second_pointer_r <= DATA_RESET;
            short_slot_a_r <= DATA_RESET;
            short_slot_b_r <= DATA_RESET;
        end else begin
            accumulator_r <= accumulator_nxt;
            first_pointer_r <= first_pointer_nxt;
            second_pointer_r <= second_pointer_nxt;
            short_slot_a_r <= short_slot_a_nxt;
            short_slot_b_r <= short_slot_b_nxt;
        end
    end

    // Reads are combinational so the sequencer sees them within its own
    // cycle; unmapped addresses return zero with data_rd_hit low.
    always_comb begin
        data_rd_hit = 1'b1;
        case (data_rd_addr)
            ADDR_ACCUM: data_rd_data = accumulator_r; // see RULE_01
            ADDR_FIRST_PTR: data_rd_data = first_pointer_r; // see RULE_02
            ADDR_SECOND_PTR: data_rd_data = second_pointer_r; // see RULE_02
            ADDR_SLOT_A: data_rd_data = short_slot_a_r; // see RULE_03
            ADDR_SLOT_B: data_rd_data = short_slot_b_r; // see RULE_03
            default: begin
                data_rd_data = 8'h00;
                data_rd_hit = 1'b0;
            end
        endcase
    end

    // The two-bit field of the one-byte short-direct opcode picks a slot;
    // timing of the four-cycle access belongs to the sequencer.
    assign short_rd_data = sel_short(short_sel, first_pointer_r,
        second_pointer_r, short_slot_a_r, short_slot_b_r); // see RULE_04 see RULE_05

    assign accumulator_out = accumulator_r;
    assign first_pointer_out = first_pointer_r;
    assign second_pointer_out = second_pointer_r;

    // ------------------------------------------------------------------
    // Flag banks and context
    // ------------------------------------------------------------------
    // The context code doubles as the bank index; the unused fourth code
    // can never be loaded, so no fourth bank is built.
    flags_type bank_r [3];
    flags_type bank_nxt [3];
    ctx_type ctx_r, ctx_nxt;
    ctx_type prev_ctx_r, prev_ctx_nxt;
    ctx_type main_ret_r, main_ret_nxt;

    // Only the active bank is visible or written; the others hold.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            bank_nxt[i] = bank_r[i]; // see RULE_14
        end
        if (flag_upd.carry_we) begin
            bank_nxt[ctx_r].carry = flag_upd.carry; // see RULE_13 see RULE_15
        end
        if (flag_upd.zero_we) begin
            bank_nxt[ctx_r].zero = flag_upd.zero; // see RULE_13 see RULE_16
        end
    end

    // Nesting depth is one level per kind: entry remembers the context
    // left behind and return goes back to it.
    // A second maskable entry from inside interrupt context overwrites
    // the stored context, so software must not nest maskable interrupts.
    always_comb begin
        ctx_nxt = ctx_r;
        prev_ctx_nxt = prev_ctx_r;
        main_ret_nxt = main_ret_r;
        case (pc_cmd.op)
            PC_VECTOR: begin
                ctx_nxt = pc_cmd.to_nmi ? CTX_NMI : CTX_IRQ; // see RULE_11
                if (pc_cmd.to_nmi) begin
                    prev_ctx_nxt = ctx_r;
                end else begin
                    main_ret_nxt = ctx_r;
                end
            end
            PC_IRET: begin
                if (ctx_r == CTX_NMI) begin
                    ctx_nxt = prev_ctx_r; // see RULE_12
                end else begin
                    ctx_nxt = main_ret_r; // see RULE_12
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                bank_r[i] <= '0; // see RULE_10
            end
            ctx_r <= CTX_NMI; // see RULE_17
            prev_ctx_r <= CTX_MAIN;
            main_ret_r <= CTX_MAIN;
        end else begin
            for (int i = 0; i < 3; i++) begin
                bank_r[i] <= bank_nxt[i];
            end
            ctx_r <= ctx_nxt;
            prev_ctx_r <= prev_ctx_nxt;
            main_ret_r <= main_ret_nxt;
        end
    end

    assign active_flags = bank_r[ctx_r]; // see RULE_13
    assign active_ctx = ctx_r;

    // ------------------------------------------------------------------
    // Program counter and return stack
    // ------------------------------------------------------------------
    // Reset loads the reset vector location straight into the counter;
    // fetching the vector word itself is left to the sequencer, which
    // then issues an ordinary jump.
    logic [11:0] pc_r, pc_nxt;
    logic [11:0] stack_r [STACK_LEVELS];
    logic [11:0] stack_nxt [STACK_LEVELS];
    logic [2:0] level_r, level_nxt;
    logic [11:0] rel_sum;

    // Offset sign-extended and added by the local rel_sum adder, wrapping at 4 KB.
    assign rel_sum = pc_r + {{4{pc_cmd.offset[7]}}, pc_cmd.offset}; // see RULE_08

    always_comb begin
        pc_nxt = pc_r;
        level_nxt = level_r;
        for (int i = 0; i < STACK_LEVELS; i++) begin
            stack_nxt[i] = stack_r[i];
        end
        case (pc_cmd.op)
            PC_INCREMENT: pc_nxt = pc_r + 12'h001; // see RULE_07 see RULE_06
            PC_RELATIVE: pc_nxt = rel_sum; // see RULE_08
            PC_JUMP: pc_nxt = pc_cmd.target; // see RULE_09
            PC_CALL, PC_VECTOR: begin
                pc_nxt = pc_cmd.target; // see RULE_09
                stack_nxt[0] = pc_r; // see RULE_18
                for (int i = 1; i < STACK_LEVELS; i++) begin
                    stack_nxt[i] = stack_r[i-1];
                end
                // At full depth the oldest entry falls off the bottom and
                // the count stays at its top, so returns still pop.
                if (level_r < 3'(STACK_LEVELS)) begin
                    level_nxt = level_r + 3'd1;
                end
            end
            PC_RETURN, PC_IRET: begin
                // Empty stack: the pop is skipped and the counter holds its value.
                if (level_r != 3'd0) begin
                    pc_nxt = stack_r[0]; // see RULE_09 see RULE_18
                    for (int i = 0; i < STACK_LEVELS - 1; i++) begin
                        stack_nxt[i] = stack_r[i+1];
                    end
                    level_nxt = level_r - 3'd1;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= RESET_VECTOR; // see RULE_09
            level_r <= 3'd0;
            for (int i = 0; i < STACK_LEVELS; i++) begin
                stack_r[i] <= PC_RESET;
            end
        end else begin
            pc_r <= pc_nxt;
            level_r <= level_nxt;
            for (int i = 0; i < STACK_LEVELS; i++) begin
                stack_r[i] <= stack_nxt[i];
            end
        end
    end

    // The level count lets the sequencer tell an empty stack from a full
    // one without reading the entries themselves.
    assign program_counter = pc_r;
    assign stack_level = level_r;

endmodule

/* sim/cpu_regs_asserts.sv */
`timescale 1ns/10ps
module cpu_regs_asserts #(
    parameter int STACK_LEVELS = 6
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input cpu_regs_pkg::data_wr_type data_wr,
    input wire logic [7:0] data_rd_addr,
    input wire logic [7:0] data_rd_data,
    input wire logic data_rd_hit,
    input wire logic [1:0] short_sel,
    input wire logic [7:0] short_rd_data,
    input wire logic accum_we,
    input wire logic [7:0] accum_alu_data,
    input cpu_regs_pkg::flag_upd_type flag_upd,
    input cpu_regs_pkg::flags_type active_flags,
    input cpu_regs_pkg::ctx_type active_ctx,
    input cpu_regs_pkg::pc_cmd_type pc_cmd,
    input wire logic [11:0] program_counter,
    input wire logic [7:0] accumulator_out,
    input wire logic [7:0] first_pointer_out,
    input wire logic [2:0] stack_level
);
    import cpu_regs_pkg::*;
    logic [11:0] rel_ext;
    assign rel_ext = {{4{pc_cmd.offset[7]}}, pc_cmd.offset};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_irq_entry;
        pc_cmd.op == PC_VECTOR && !pc_cmd.to_nmi;
    endsequence
    sequence s_quiet;
        pc_cmd.op inside {PC_HOLD, PC_INCREMENT};
    endsequence
    a_ptr_write: assert property (
        data_wr.wr && data_wr.addr == ADDR_FIRST_PTR
        |=> first_pointer_out == $past(data_wr.data))
        else $error("pointer write lost");
    a_accum_alu: assert property (
        accum_we && !data_wr.wr |=> accumulator_out == $past(accum_alu_data))
        else $error("alu result not in accumulator");
    a_accum_read: assert property (
        data_rd_addr == ADDR_ACCUM
        |-> data_rd_hit && data_rd_data == accumulator_out)
        else $error("accumulator not readable in data space");
    a_short_mux: assert property (
        short_sel == 2'h0 |-> short_rd_data == first_pointer_out)
        else $error("short slot zero is not the first pointer");
    a_pc_step: assert property (
        pc_cmd.op == PC_INCREMENT
        |=> program_counter == $past(program_counter) + 12'h001)
        else $error("counter did not step by one");
    a_pc_branch: assert property (
        pc_cmd.op == PC_RELATIVE
        |=> program_counter == $past(program_counter) + $past(rel_ext))
        else $error("relative branch sum wrong");
    a_pc_jump: assert property (
        pc_cmd.op == PC_JUMP |=> program_counter == $past(pc_cmd.target))
        else $error("jump target not loaded");
    a_irq_entry: assert property (
        s_irq_entry |=> active_ctx == CTX_IRQ)
        else $error("interrupt context not entered");
    a_flag_carry: assert property (
        s_quiet ##0 flag_upd.carry_we
        |=> active_flags.carry == $past(flag_upd.carry))
        else $error("carry update lost");
    a_flags_hold: assert property (
        s_quiet ##0 (!flag_upd.carry_we && !flag_upd.zero_we)
        |=> $stable(active_flags))
        else $error("flags changed without update");
    a_stack_push: assert property (
        pc_cmd.op == PC_CALL && stack_level < 3'(STACK_LEVELS)
        |=> stack_level == $past(stack_level) + 3'h1)
        else $error("call did not deepen stack");
endmodule
bind cpu_register_file_flag_banks cpu_regs_asserts #(
    .STACK_LEVELS(STACK_LEVELS)
) cpu_regs_asserts_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .data_wr(data_wr),
    .data_rd_addr(data_rd_addr), .data_rd_data(data_rd_data),
    .data_rd_hit(data_rd_hit), .short_sel(short_sel),
    .short_rd_data(short_rd_data), .accum_we(accum_we),
    .accum_alu_data(accum_alu_data), .flag_upd(flag_upd),
    .active_flags(active_flags), .active_ctx(active_ctx),
    .pc_cmd(pc_cmd), .program_counter(program_counter),
    .accumulator_out(accumulator_out),
    .first_pointer_out(first_pointer_out), .stack_level(stack_level)
);

/* sim/alu_model.sv */
`timescale 1ns/10ps
module alu_model (
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic subtract,
    output logic [7:0] result,
    output cpu_regs_pkg::flag_upd_type upd
);
    import cpu_regs_pkg::*;
    logic [8:0] sum;
    // The ninth bit is the carry on add and the borrow on subtract.
    always_comb begin
        sum = subtract ? {1'b0, op_a} - {1'b0, op_b} : {1'b0, op_a} + op_b;
        result = sum[7:0];
        upd = '{1'b1, sum[8], 1'b1, sum[7:0] == 8'h00};
    end
endmodule

/* sim/cpu_register_file_flag_banks_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("[FAIL] %s expected %h seen %h", nm, (exp), (got)); \
    end \
end
module cpu_register_file_flag_banks_tb;
    import cpu_regs_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    data_wr_type data_wr = '0;
    logic [7:0] data_rd_addr = 8'h00;
    logic [1:0] short_sel = 2'h0;
    logic accum_we = 1'b0;
    flag_upd_type flag_upd = '0;
    pc_cmd_type pc_cmd = '0;
    logic [7:0] op_a = 8'h00, op_b = 8'h00;
    logic subtract = 1'b0;
    logic [7:0] rd_data, short_data, alu_data, acc, ptr0, ptr1;
    logic rd_hit;
    flag_upd_type alu_upd;
    flags_type flags_now;
    ctx_type ctx;
    logic [11:0] pc;
    logic [2:0] level;
    int fail_count = 0;
    int check_count = 0;
    logic [7:0] addrs [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    always #2.5 ref_clk = ~ref_clk;
    cpu_register_file_flag_banks cpu_register_file_flag_banks_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .data_wr(data_wr),
        .data_rd_addr(data_rd_addr), .data_rd_data(rd_data),
        .data_rd_hit(rd_hit), .short_sel(short_sel),
        .short_rd_data(short_data), .accum_we(accum_we),
        .accum_alu_data(alu_data), .flag_upd(flag_upd),
        .active_flags(flags_now), .active_ctx(ctx), .pc_cmd(pc_cmd),
        .program_counter(pc), .accumulator_out(acc),
        .first_pointer_out(ptr0), .second_pointer_out(ptr1),
        .stack_level(level)
    );
    alu_model alu_model_inst (
        .op_a(op_a), .op_b(op_b), .subtract(subtract),
        .result(alu_data), .upd(alu_upd)
    );
    task conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // One-cycle requests, entered and left at falling edges
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        data_wr = '{1'b1, a, d};
        @(negedge ref_clk);
        data_wr = '0;
    endtask
    task automatic pcop(input pc_op_type op, input logic [11:0] t,
            input logic [7:0] o, input logic n);
        @(negedge ref_clk);
        pc_cmd = '{op, t, o, n};
        @(negedge ref_clk);
        pc_cmd = '0;
    endtask
    task automatic flags(input logic c, input logic z);
        @(negedge ref_clk);
        flag_upd = '{1'b1, c, 1'b1, z};
        @(negedge ref_clk);
        flag_upd = '0;
    endtask
    task automatic alu_chk(input logic [7:0] a, input logic [7:0] b,
            input logic s, input logic [7:0] res, input logic [1:0] fl);
        @(negedge ref_clk);
        op_a = a;
        op_b = b;
        subtract = s;
        @(negedge ref_clk);
        accum_we = 1'b1;
        flag_upd = alu_upd;
        @(negedge ref_clk);
        accum_we = 1'b0;
        flag_upd = '0;
        `CHK("accumulator", res, acc)
        `CHK("alu flags", fl, flags_now)
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK("reset pc", RESET_VECTOR, pc)
        `CHK("reset ctx", CTX_NMI, ctx)
        for (int i = 0; i < 5; i++) begin
            wr(addrs[i], 8'h5a ^ 8'(i));
            data_rd_addr = addrs[i];
            #1;
            `CHK("data read", 8'h5a ^ 8'(i), rd_data)
            `CHK("data hit", 1'b1, rd_hit)
        end
        `CHK("pointers", 16'h5b5a, {ptr1, ptr0})
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            short_sel = 2'(i);
            #1;
            `CHK("short read", 8'h5a ^ 8'(i), short_data)
        end
        wr(8'h84, 8'h77);
        data_rd_addr = 8'h84;
        #1;
        `CHK("unmapped", 9'h000, {rd_hit, rd_data})
        alu_chk(8'hf0, 8'h20, 1'b0, 8'h10, 2'b10);
        alu_chk(8'h20, 8'h20, 1'b1, 8'h00, 2'b01);
        alu_chk(8'h10, 8'h20, 1'b1, 8'hf0, 2'b10);
        pcop(PC_JUMP, 12'hfff, 8'h00, 1'b0);
        pcop(PC_INCREMENT, 12'h000, 8'h00, 1'b0);
        `CHK("pc wrap", 12'h000, pc)
        pcop(PC_RELATIVE, 12'h000, 8'hfe, 1'b0);
        `CHK("pc back", 12'hffe, pc)
        pcop(PC_RELATIVE, 12'h000, 8'h05, 1'b0);
        `CHK("pc fwd", 12'h003, pc)
        for (int k = 1; k < 8; k++) begin
            pcop(PC_CALL, 12'(k * 16), 8'h00, 1'b0);
        end
        `CHK("stack full", 3'h6, level)
        pcop(PC_RETURN, 12'h000, 8'h00, 1'b0);
        `CHK("pc pop", 15'h5060, {level, pc})
        pcop(PC_VECTOR, 12'hff0, 8'h00, 1'b0);
        `CHK("irq entry", {CTX_IRQ, 12'hff0}, {ctx, pc})
        `CHK("irq flags", 2'b00, flags_now)
        flags(1'b0, 1'b1);
        pcop(PC_IRET, 12'h000, 8'h00, 1'b0);
        `CHK("back nmi", {CTX_NMI, 2'b10}, {ctx, flags_now})
        pcop(PC_IRET, 12'h000, 8'h00, 1'b0);
        `CHK("main", {CTX_MAIN, 2'b00}, {ctx, flags_now})
        flags(1'b1, 1'b1);
        pcop(PC_VECTOR, 12'hffc, 8'h00, 1'b1);
        `CHK("nmi kept", {CTX_NMI, 2'b10}, {ctx, flags_now})
        pcop(PC_IRET, 12'h000, 8'h00, 1'b0);
        `CHK("main kept", {CTX_MAIN, 2'b11}, {ctx, flags_now})
        conclude();
    end
    // The sequence needs about 80 cycles; allow fifty times that.
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
endmodule
